// >>> cft_can_node.sv
`timescale 1ns/10ps
// remote node: takes frames, answers remote frames, sends own frames on command
module cft_can_node #(
	parameter [31:0] KEY = 32'h5a5a0000 // reply payload pattern
) (
	input wire i_ref_clk,
	input wire i_tx_valid,
	input wire i_tx_remote,
	input wire [10:0] i_tx_id,
	input wire i_stall, // slow node: hold off acceptance
	input wire i_req, // send one frame of our own
	input wire i_req_rem,
	input wire [10:0] i_req_id,
	output wire o_tx_ready,
	output reg o_rx_valid = 1'b0,
	output reg o_rx_remote = 1'b0,
	output reg [10:0] o_rx_id = 11'h000,
	output reg [31:0] o_rx_data = 32'h0
);
	assign o_tx_ready = i_tx_valid && !i_stall;
	// idle receive lines toggle so that stale values never pass
	always @(posedge i_ref_clk) begin
		o_rx_valid <= 1'b0;
		o_rx_remote <= ~o_rx_remote;
		o_rx_id <= ~o_rx_id;
		o_rx_data <= ~o_rx_data;
		if (i_tx_valid && o_tx_ready && i_tx_remote) begin
			// answer with the data frame of the same id
			o_rx_valid <= 1'b1;
			o_rx_remote <= 1'b0;
			o_rx_id <= i_tx_id;
			o_rx_data <= KEY ^ {21'h0, i_tx_id};
		end else if (i_req) begin
			// own event, no periodic requests
			o_rx_valid <= 1'b1;
			o_rx_remote <= i_req_rem;
			o_rx_id <= i_req_id;
			o_rx_data <= KEY ^ {21'h0, i_req_id};
		end
	end
endmodule // cft_can_node

// >>> cft_frame_timing.v
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "cft_regs.vh"
module cft_frame_timing #(
	parameter INTV_W = 32 // repeat interval counter width
) (
	input wire i_ref_clk,
	input wire i_resetn,
	input wire i_ce,
	// apb slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output wire o_pslverr,
	output reg [31:0] o_prdata,
	// frame transmit request to the can controller
	output reg o_tx_valid,
	input wire i_tx_ready,
	output reg o_tx_remote,
	output reg [10:0] o_tx_id,
	output reg [31:0] o_tx_data,
	// received frame from the can controller
	input wire i_rx_valid,
	input wire i_rx_remote,
	input wire [10:0] i_rx_id,
	input wire [31:0] i_rx_data,
	// transceiver
	input wire i_wake_pin, // asynchronous bus wakeup detect
	output wire [2:0] o_xcvr_state,
	output reg o_xcvr_ext, // external transceiver selected
	output reg [7:0] o_xcvr_ext_cfg
);
	reg [31:0] cfg_r; // timing type, direction, stream, id
	reg [INTV_W-1:0] intv_r; // repeat interval in cycles
	reg [31:0] wdata_r; // held host data
	reg pend_r; // host write pending
	reg run_r; // session started
	reg [INTV_W-1:0] gap_r; // cycles since last send
	reg gap_ok_r; // interval has elapsed
	reg [31:0] rxdata_r; // data for the host reader
	reg rx_full_r; // reader data available
	reg rx_rem_r; // reader frame was remote
	reg [10:0] rx_id_r;
	reg xcmd_v_r; // transceiver command pulse
	reg [2:0] xcmd_r;
	reg start_p_r; // interface start pulse
	reg close_p_r; // close last session pulse
	reg wake_s1_r; // wakeup synchroniser
	reg wake_s2_r;
	wire [1:0] ttype = cfg_r[`CFT_CFG_TIMING_HI:`CFT_CFG_TIMING_LO];
	wire is_out = cfg_r[`CFT_CFG_OUTPUT];
	wire is_stream = cfg_r[`CFT_CFG_STREAM];
	wire [10:0] fid = cfg_r[`CFT_CFG_ID_HI:`CFT_CFG_ID_LO];
	wire wr_acc = i_psel & i_penable & i_pwrite; // write access phase
	wire rd_acc = i_psel & i_penable & ~i_pwrite; // read access phase
	wire hw_write = wr_acc && i_paddr == `CFT_OFF_TXWR; // host frame write call
	wire hw_read = rd_acc && i_paddr == `CFT_OFF_RXDATA; // host frame read call
	wire send = o_tx_valid & i_tx_ready; // frame accepted by controller
	wire rx_match = i_rx_valid && i_rx_id == fid;
	wire req_in = rx_match & i_rx_remote; // matching remote request
	reg known; // address decodes
	// apb answers in the access cycle with no wait states
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~known;
	// address decode and read mux
	always @* begin
		known = 1'b1;
		o_prdata = 32'h00000000;
		case (i_paddr)
			`CFT_OFF_CTRL: o_prdata = {30'h00000000, 1'b0, run_r};
			`CFT_OFF_CFG: o_prdata = cfg_r;
			`CFT_OFF_TXWR: o_prdata = wdata_r;
			`CFT_OFF_XCVR: o_prdata = {29'h00000000, o_xcvr_state};
			`CFT_OFF_STAT: o_prdata = {16'h0000, 1'b0, rx_id_r, pend_r, rx_rem_r, rx_full_r, o_tx_valid};
			`CFT_OFF_RXDATA: o_prdata = rxdata_r;
			`CFT_OFF_INTV: o_prdata = intv_r;
			default: known = 1'b0;
		endcase
	end
	// configuration and transceiver command registers
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_r <= `CFT_CFG_RST;
			intv_r <= `CFT_INTV_RST;
			run_r <= 1'b0;
			start_p_r <= 1'b0;
			close_p_r <= 1'b0;
			xcmd_v_r <= 1'b0;
			xcmd_r <= `CFT_XS_POWERON;
			o_xcvr_ext <= 1'b0;
			o_xcvr_ext_cfg <= 8'h00;
		end else if (i_ce) begin
			start_p_r <= 1'b0;
			close_p_r <= 1'b0;
			xcmd_v_r <= 1'b0;
			if (wr_acc && i_paddr == `CFT_OFF_CTRL) begin
				// start runs the session, close ends it
				if (i_pwdata[`CFT_CTRL_CLOSE]) begin
					run_r <= 1'b0;
					close_p_r <= 1'b1;
				end else if (i_pwdata[`CFT_CTRL_START]) begin
					run_r <= 1'b1;
					start_p_r <= 1'b1;
				end
			end
			if (wr_acc && i_paddr == `CFT_OFF_CFG) begin
				cfg_r <= i_pwdata;
				o_xcvr_ext <= i_pwdata[`CFT_CFG_EXTXCVR];
				o_xcvr_ext_cfg <= i_pwdata[`CFT_CFG_EXTCFG_HI:`CFT_CFG_EXTCFG_LO];
			end
			if (wr_acc && i_paddr == `CFT_OFF_INTV) begin
				intv_r <= i_pwdata[INTV_W-1:0];
			end
			if (wr_acc && i_paddr == `CFT_OFF_XCVR) begin
				xcmd_v_r <= 1'b1;
				xcmd_r <= i_pwdata[2:0];
			end
		end
	end
	// repeat interval timer, restarted by every send
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			gap_r <= {INTV_W{1'b0}};
			gap_ok_r <= 1'b1;
		end else if (i_ce) begin
			if (start_p_r || send) begin
				gap_r <= {INTV_W{1'b0}};
				gap_ok_r <= 1'b0;
			end else if (!gap_ok_r) begin
				gap_r <= gap_r + 1'b1;
				if (gap_r + 1'b1 >= intv_r) gap_ok_r <= 1'b1;
			end
		end
	end
	// frame scheduler
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wdata_r <= 32'h00000000;
			pend_r <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_remote <= 1'b0;
			o_tx_id <= 11'h000;
			o_tx_data <= 32'h00000000;
		end else if (i_ce) begin
			if (send) o_tx_valid <= 1'b0;
			if (hw_write) begin
				wdata_r <= i_pwdata;
				pend_r <= 1'b1; // extra writes merge into one request
			end else if (send && !o_tx_remote && !is_stream) begin
				pend_r <= 1'b0;
			end
			if (close_p_r || !run_r) begin
				o_tx_valid <= 1'b0;
				pend_r <= 1'b0;
			end else if (is_stream) begin
				// one frame per write made while no frame is waiting, remote bit taken from data msb
				if (hw_write && !o_tx_valid) begin
					o_tx_valid <= 1'b1;
					o_tx_remote <= i_pwdata[31];
					o_tx_id <= fid;
					o_tx_data <= i_pwdata;
				end
			end else if (!o_tx_valid || send) begin
				case (ttype)
					`CFT_TT_EVDATA: begin
						if (is_out && pend_r && gap_ok_r && !send) begin
							o_tx_valid <= 1'b1;
							o_tx_remote <= 1'b0;
							o_tx_id <= fid;
							o_tx_data <= wdata_r;
						end
					end
					`CFT_TT_CYCREM: begin
						if (!is_out && (start_p_r || (gap_ok_r && !send))) begin
							o_tx_valid <= 1'b1;
							o_tx_remote <= 1'b1;
							o_tx_id <= fid;
						end else if (is_out && req_in && pend_r) begin
							o_tx_valid <= 1'b1;
							o_tx_remote <= 1'b0;
							o_tx_id <= fid;
							o_tx_data <= wdata_r;
						end
					end
					`CFT_TT_EVREM: begin
						if (!is_out && pend_r && !send) begin
							o_tx_valid <= 1'b1;
							o_tx_remote <= 1'b1;
							o_tx_id <= fid;
							// a write landing in this same cycle is a new event and keeps its request
							if (!hw_write) pend_r <= 1'b0; // data discarded
						end else if (is_out && req_in && pend_r) begin
							o_tx_valid <= 1'b1;
							o_tx_remote <= 1'b0;
							o_tx_id <= fid;
							o_tx_data <= wdata_r;
						end
					end
					default: begin
						o_tx_valid <= 1'b0;
					end
				endcase
			end
		end
	end
	// reader path: replies delivered, remote requests consumed in non-stream output modes
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rxdata_r <= 32'h00000000;
			rx_full_r <= 1'b0;
			rx_rem_r <= 1'b0;
			rx_id_r <= 11'h000;
		end else if (i_ce) begin
			if (i_rx_valid && is_stream) begin
				rxdata_r <= i_rx_data;
				rx_rem_r <= i_rx_remote;
				rx_id_r <= i_rx_id;
				rx_full_r <= 1'b1;
			end else if (rx_match && !i_rx_remote && !is_out) begin
				rxdata_r <= i_rx_data;
				rx_rem_r <= 1'b0;
				rx_id_r <= i_rx_id;
				rx_full_r <= 1'b1;
			end else if (hw_read) begin
				rx_full_r <= 1'b0; // new frame wins over the read clear
			end
		end
	end
	// wakeup pin synchroniser
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wake_s1_r <= 1'b0;
			wake_s2_r <= 1'b0;
		end else if (i_ce) begin
			wake_s1_r <= i_wake_pin;
			wake_s2_r <= wake_s1_r;
		end
	end
	// transceiver state machine
	cft_xcvr_fsm u_xcvr (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_close_last(close_p_r),
		.i_if_start(start_p_r),
		.i_cmd_valid(xcmd_v_r),
		.i_cmd_state(xcmd_r),
		.i_wake_pattern(wake_s2_r),
		.o_state(o_xcvr_state)
	);
endmodule // cft_frame_timing

// >>> cft_frame_timing_assertions.sv
`timescale 1ns/10ps
`include "cft_regs.vh"
// port checks of frame handshake and transceiver machine
module cft_timing_chk #(
	parameter INTV_W = 32
) (
	input wire i_ref_clk,
	input wire i_resetn,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire i_tx_ready,
	input wire i_wake_pin,
	input wire o_pready,
	input wire o_tx_valid,
	input wire o_tx_remote,
	input wire [10:0] o_tx_id,
	input wire [31:0] o_tx_data,
	input wire [2:0] o_xcvr_state
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	// session close written: the next edge may drop a frame that is still waiting
	wire close_wr = i_psel && i_penable && i_pwrite && i_paddr == `CFT_OFF_CTRL && i_pwdata[`CFT_CTRL_CLOSE];
	// request not yet taken
	sequence s_pend;
		o_tx_valid && !i_tx_ready;
	endsequence
	// asleep, bus wake seen, no apb traffic
	sequence s_wake;
		o_xcvr_state == `CFT_XS_SLEEP && $rose(i_wake_pin) && !i_psel;
	endsequence
	property p_hold;
		s_pend ##0 !$past(close_wr) |=> o_tx_valid && $stable(o_tx_id) && $stable(o_tx_data) && $stable(o_tx_remote);
	endproperty
	a_hold: assert property (p_hold) else $error("frame changed before taken");
	property p_drop;
		o_tx_valid && i_tx_ready |=> !o_tx_valid;
	endproperty
	a_drop: assert property (p_drop) else $error("frame resent at once");
	property p_rst;
		$rose(i_resetn) |-> o_xcvr_state == `CFT_XS_POWERON && !o_tx_valid;
	endproperty
	a_rst: assert property (p_rst) else $error("not power-on after reset");
	property p_slp;
		$changed(o_xcvr_state) && o_xcvr_state == `CFT_XS_SLEEP |->
			$past(o_xcvr_state) inside {`CFT_XS_NORMAL, `CFT_XS_SWWAKE};
	endproperty
	a_slp: assert property (p_slp) else $error("bad entry to sleep");
	property p_wak;
		$changed(o_xcvr_state) && o_xcvr_state == `CFT_XS_SWWAKE |->
			$past(o_xcvr_state) != `CFT_XS_SWFAST;
	endproperty
	a_wak: assert property (p_wak) else $error("bad entry to wake");
	property p_fast;
		$past(o_xcvr_state) == `CFT_XS_SWFAST && $changed(o_xcvr_state) |->
			o_xcvr_state inside {`CFT_XS_NORMAL, `CFT_XS_POWERON};
	endproperty
	a_fast: assert property (p_fast) else $error("bad exit from fast");
	property p_wpin;
		s_wake |-> ##[1:5] o_xcvr_state == `CFT_XS_NORMAL;
	endproperty
	a_wpin: assert property (p_wpin) else $error("bus wake ignored");
	property p_rdy;
		i_psel && i_penable |-> o_pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("apb not ready");
endmodule // cft_timing_chk
bind cft_frame_timing cft_timing_chk #(.INTV_W(INTV_W)) i_chk (.i_ref_clk, .i_resetn, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_tx_ready, .i_wake_pin, .o_pready, .o_tx_valid, .o_tx_remote, .o_tx_id,
	.o_tx_data, .o_xcvr_state);

// >>> cft_regs.vh
`ifndef CFT_REGS_VH
`define CFT_REGS_VH
// apb register byte offsets
`define CFT_OFF_CTRL 12'h000
`define CFT_OFF_CFG 12'h004
`define CFT_OFF_TXWR 12'h008
`define CFT_OFF_XCVR 12'h00c
`define CFT_OFF_STAT 12'h010
`define CFT_OFF_RXDATA 12'h014
`define CFT_OFF_INTV 12'h018
// ctrl register fields
`define CFT_CTRL_START 0
`define CFT_CTRL_CLOSE 1
// cfg register fields
`define CFT_CFG_TIMING_LO 0
`define CFT_CFG_TIMING_HI 1
`define CFT_CFG_OUTPUT 2
`define CFT_CFG_STREAM 3
`define CFT_CFG_EXTXCVR 4
`define CFT_CFG_EXTCFG_LO 8
`define CFT_CFG_EXTCFG_HI 15
`define CFT_CFG_ID_LO 16
`define CFT_CFG_ID_HI 26
// frame timing types
`define CFT_TT_EVDATA 2'h0
`define CFT_TT_CYCREM 2'h1
`define CFT_TT_EVREM 2'h2
// transceiver states
`define CFT_XS_POWERON 3'h0
`define CFT_XS_NORMAL 3'h1
`define CFT_XS_SLEEP 3'h2
`define CFT_XS_SWWAKE 3'h3
`define CFT_XS_SWFAST 3'h4
// reset values
`define CFT_CFG_RST 32'h00000000
`define CFT_INTV_RST 32'h000003e8
`endif

// >>> cft_xcvr_fsm.v
`timescale 1ns/10ps
`include "cft_regs.vh"
// transceiver control state machine
module cft_xcvr_fsm (
	input wire i_ref_clk,
	input wire i_resetn,
	input wire i_ce,
	input wire i_close_last, // last session closed
	input wire i_if_start, // interface start pulse
	input wire i_cmd_valid, // software target state command
	input wire [2:0] i_cmd_state,
	input wire i_wake_pattern, // synchronised bus wakeup detect
	output reg [2:0] o_state
);
	localparam POWERON = `CFT_XS_POWERON;
	localparam NORMAL = `CFT_XS_NORMAL;
	localparam SLEEP = `CFT_XS_SLEEP;
	localparam SWWAKE = `CFT_XS_SWWAKE;
	localparam SWFAST = `CFT_XS_SWFAST;
	reg [2:0] state_nxt; // next state
	// next state from bus events and commands
	always @* begin
		state_nxt = o_state;
		if (i_close_last) begin
			state_nxt = POWERON;
		end else if (i_cmd_valid) begin
			case (i_cmd_state)
				NORMAL: begin
					if (o_state != NORMAL) state_nxt = NORMAL;
				end
				SLEEP: begin
					// only normal or wake may sleep; others hold
					if (o_state == NORMAL || o_state == SWWAKE) state_nxt = SLEEP;
				end
				SWWAKE: begin
					if (o_state == POWERON || o_state == NORMAL || o_state == SLEEP) state_nxt = SWWAKE;
				end
				SWFAST: begin
					if (o_state != SWFAST) state_nxt = SWFAST;
				end
				default: begin
					state_nxt = o_state;
				end
			endcase
		end else if (i_if_start && o_state == POWERON) begin
			state_nxt = NORMAL;
		end else if (i_wake_pattern && o_state == SLEEP) begin
			state_nxt = NORMAL;
		end
	end
	// state register
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_state <= POWERON;
		end else if (i_ce) begin
			o_state <= state_nxt;
		end
	end
endmodule // cft_xcvr_fsm

// >>> testbench.sv
`timescale 1ns/10ps
`include "cft_regs.vh"
module testbench;
	localparam [10:0] ID = 11'h123;
	localparam [31:0] KEY = 32'h5a5a0000;
	localparam [31:0] RP = KEY ^ {21'h0, ID}; // reply payload
	// command/expected pairs, entry 0 in the low bits
	localparam [47:0] TT = {3'h1,3'h1,3'h4,3'h4,3'h1,3'h1,3'h3,3'h4,3'h2,3'h4,3'h4,3'h4,3'h2,3'h2,3'h3,3'h3};
	reg clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, stall = 1'b0, req = 1'b0, rrem = 1'b0;
	reg wpin = 1'b0;
	reg e;
	reg [11:0] addr = 12'h000;
	reg [31:0] wd = 32'h0, r, ldat;
	reg [10:0] rid = 11'h000;
	reg [10:0] lid = 11'h000; // id of the last accepted frame
	wire rdy, err, txv, txr, txrem, rxv, rxrem, xe;
	wire [31:0] rd, txd, rxd;
	wire [10:0] txid, rxid;
	wire [2:0] xs;
	wire [7:0] xc;
	integer error_cnt = 0, check_count = 0, cyc = 0, nfr = 0, nrem = 0, last = 0, gap = 0, t;
	cft_frame_timing i_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_ce(1'b1), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_pready(rdy), .o_pslverr(err), .o_prdata(rd),
		.o_tx_valid(txv), .i_tx_ready(txr), .o_tx_remote(txrem), .o_tx_id(txid), .o_tx_data(txd),
		.i_rx_valid(rxv), .i_rx_remote(rxrem), .i_rx_id(rxid), .i_rx_data(rxd), .i_wake_pin(wpin),
		.o_xcvr_state(xs), .o_xcvr_ext(xe), .o_xcvr_ext_cfg(xc));
	cft_can_node #(.KEY(KEY)) i_node (.i_ref_clk(clk), .i_tx_valid(txv), .i_tx_remote(txrem), .i_tx_id(txid),
		.i_stall(stall), .i_req(req), .i_req_rem(rrem), .i_req_id(rid), .o_tx_ready(txr), .o_rx_valid(rxv),
		.o_rx_remote(rxrem), .o_rx_id(rxid), .o_rx_data(rxd));
	initial forever #50 clk = ~clk;
	// frame monitor: count, shortest spacing, last payload; hang guard
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (txv === 1'b1 && txr === 1'b1) begin
			if (nfr > 0 && cyc - last < gap) gap = cyc - last;
			last = cyc;
			nfr = nfr + 1;
			nrem = nrem + txrem;
			ldat = txd;
			lid = txid;
		end
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			end_of_test;
		end
	end
	task end_of_test;
		if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input [32:0] g, input [32:0] x);
		check_count = check_count + 1;
		if (g !== x) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
			error_cnt = error_cnt + 1;
		end
	endtask
	// one apb transfer, held until pready is sampled
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		r = rd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wt(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// close, configure, start, clear counts
	task go(input [31:0] c);
		apb(1'b1, `CFT_OFF_CTRL, 32'h2);
		apb(1'b1, `CFT_OFF_CFG, c);
		apb(1'b1, `CFT_OFF_CTRL, 32'h1);
		nfr = 0;
		nrem = 0;
		gap = 100000;
	endtask
	// node raises one frame of its own
	task node(input [10:0] i, input m);
		@(posedge clk);
		req <= 1'b1;
		rid <= i;
		rrem <= m;
		@(posedge clk);
		req <= 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, `CFT_OFF_CFG, 0); chk(r, `CFT_CFG_RST);
		apb(1'b0, `CFT_OFF_INTV, 0); chk(r, `CFT_INTV_RST);
		apb(1'b0, `CFT_OFF_XCVR, 0); chk(r, 0);
		apb(1'b0, 12'h01c, 0); chk({e, r}, 33'h100000000);
		apb(1'b1, `CFT_OFF_INTV, 20);
		// event data: start restarts the interval, so let it run out; slow node holds the first frame,
		// second write lands inside the interval and must wait
		go({ID, 16'h0004}); stall <= 1'b1; wt(25);
		apb(1'b1, `CFT_OFF_TXWR, 32'h11); wt(5); @(posedge clk); stall <= 1'b0; wt(3);
		apb(1'b1, `CFT_OFF_TXWR, 32'h22); wt(70);
		chk(nfr, 2); chk(gap >= 20, 1); chk(ldat, 32'h22); chk(lid, ID);
		// cyclic remote input: repeats with no writes, reply goes to reader
		go({ID, 16'h0001}); wt(60);
		chk(nrem, 3); chk(nfr, 3);
		apb(1'b0, `CFT_OFF_RXDATA, 0); chk(r, RP);
		// remote-triggered output, cyclic and event remote
		for (t = 1; t < 3; t = t + 1) begin
			go({ID, 16'h0004} | t); apb(1'b0, `CFT_OFF_RXDATA, 0);
			apb(1'b1, `CFT_OFF_TXWR, 32'h30 + t); wt(30); chk(nfr, 0);
			node(ID + 11'h1, 1'b1); wt(5); chk(nfr, 0);
			node(ID, 1'b1); wt(5); chk(nfr, 1); chk(ldat, 32'h30 + t); chk(nrem, 0);
			apb(1'b0, `CFT_OFF_STAT, 0); chk(r[1], 0);
		end
		// event remote input: one request per write, payload dropped
		go({ID, 16'h0002}); apb(1'b1, `CFT_OFF_TXWR, 32'hffffffff); wt(30);
		chk(nrem, 1); chk(nfr, 1);
		// stream output: remote and data frames once each
		go({ID, 16'h000c}); apb(1'b1, `CFT_OFF_TXWR, 32'h80000000);
		apb(1'b1, `CFT_OFF_TXWR, 32'h44); wt(40);
		chk(nrem, 1); chk(nfr, 2); chk(ldat, 32'h44);
		// stream input passes a remote frame to the reader
		go({ID, 16'h0008}); node(11'h007, 1'b1); wt(3);
		apb(1'b0, `CFT_OFF_STAT, 0); chk(r[14:1], {11'h007, 3'h3});
		// transceiver machine
		go(32'h0000a510); wt(3); chk({xe, xc, xs}, {1'b1, 8'ha5, `CFT_XS_NORMAL});
		for (t = 0; t < 8; t = t + 1) begin
			apb(1'b1, `CFT_OFF_XCVR, TT[t * 6 + 3 +: 3]); wt(3); chk(xs, TT[t * 6 +: 3]);
		end
		apb(1'b1, `CFT_OFF_XCVR, `CFT_XS_SLEEP); wt(3); @(posedge clk); wpin <= 1'b1; wt(8); chk(xs, `CFT_XS_NORMAL);
		@(posedge clk);
		wpin <= 1'b0;
		apb(1'b1, `CFT_OFF_CTRL, 32'h2); wt(3); chk(xs, `CFT_XS_POWERON);
		apb(1'b1, `CFT_OFF_XCVR, `CFT_XS_SLEEP); wt(3); chk(xs, `CFT_XS_POWERON);
		apb(1'b1, `CFT_OFF_XCVR, `CFT_XS_SWWAKE); wt(3); chk(xs, `CFT_XS_SWWAKE);
		end_of_test;
	end
endmodule // testbench
